//--- rtl/ulp_pkg.sv
// Package for the list pointer register bank: offsets, field layout, reset values.
// Assumes a 32-bit register access port with byte offsets inside the function window.
package ulp_pkg;
  localparam logic [7:0] OFF_COMM_AREA = 8'h18;
  localparam logic [7:0] OFF_PERIODIC_CUR = 8'h1c;
  localparam logic [7:0] OFF_CONTROL_HEAD = 8'h20;
  localparam int COMM_AREA_LSB = 8;
  localparam int PTR_LSB = 4;
  localparam logic [31:0] COMM_AREA_MASK = 32'hffffff00;
  localparam logic [31:0] PTR_MASK = 32'hfffffff0;
  localparam logic [31:0] RST_VAL = 32'h00000000;
  localparam logic [31:0] OFF_PERIODIC_IN_AREA = 32'h00000000;
  localparam logic [31:0] OFF_CONTROL_IN_AREA = 32'h00000004;
  typedef enum logic [1:0] {ULP_IDLE, ULP_FETCH, ULP_WAIT} ulp_state_t;
endpackage

//--- rtl/ulp_mem_if.sv
// Interface between the register bank and its memory fetch helper.
// Assumes a single clock domain.
`timescale 1ns/100ps
interface ulp_mem_if;
  logic req;
  logic [31:0] addr;
  logic done;
  logic [31:0] data;
  modport bank (output req, output addr, input done, input data);
  modport fetch (input req, input addr, output done, output data);
endinterface

//--- rtl/ulp_fetch.sv
// Memory fetch helper: one read of system memory per request, data registered.
// Assumes the memory port answers with a one-cycle valid pulse.
`timescale 1ns/100ps
module ulp_fetch
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Bank side
  ulp_mem_if.fetch mif,
  // System memory read port
  output logic mem_rd_o,
  output logic [31:0] mem_addr_o,
  input wire logic mem_valid_i,
  input wire logic [31:0] mem_data_i
);
  typedef struct packed
  {
    logic busy;
    logic done;
    logic [31:0] addr;
    logic [31:0] data;
  } ulp_fetch_t;
  ulp_fetch_t s_r;
  ulp_fetch_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy && mif.req)
    begin
      s_nxt.busy = 1'b1;
      s_nxt.addr = mif.addr;
    end
    else if (s_r.busy && mem_valid_i)
    begin
      s_nxt.busy = 1'b0;
      s_nxt.done = 1'b1;
      s_nxt.data = mem_data_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign mem_rd_o = s_r.busy;
  assign mem_addr_o = s_r.addr;
  assign mif.done = s_r.done;
  assign mif.data = s_r.data;

  a_fetch_done: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_r.busy && mem_valid_i |=> mif.done && mif.data == $past(mem_data_i))
    else $error("fetch data not returned");
endmodule

//--- rtl/ulp_regs.sv
// List pointer register bank: communication area base, periodic current and control head.
// Assumes a synchronous 32-bit register port and a list walker reporting descriptor updates.
`timescale 1ns/100ps
// Summary of operation
// [R1] Communication area base low eight bits read zero
// [R2] Software writes ones to find alignment
// [R3] Base address bits 31:8 read/write at 18h
// [R4] Base addresses shared control structures and table
// [R5] Software writes reserved bits with reset value
// [R6] Periodic current pointer bits 31:4 at 1Ch
// [R7] Controller updates periodic pointer; software read-only
// [R8] Software may read periodic pointer anytime
// [R9] Control list walk starts at head 20h
// [R10] Control head loaded from area at init
// [R11] All pointers clear to zero on reset
module ulp_regs
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register access port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // List walker
  input wire logic init_start_i,
  output logic init_busy_o,
  input wire logic periodic_upd_i,
  input wire logic [31:0] periodic_ptr_i,
  output logic [31:0] comm_area_base_o,
  output logic [31:0] periodic_current_descriptor_o,
  output logic [31:0] control_list_head_o,
  // System memory read port
  output logic mem_rd_o,
  output logic [31:0] mem_addr_o,
  input wire logic mem_valid_i,
  input wire logic [31:0] mem_data_i
);
  typedef struct packed
  {
    ulp_pkg::ulp_state_t st;
    logic [31:0] comm_area;
    logic [31:0] periodic_cur;
    logic [31:0] control_head;
    logic [31:0] rdata;
  } ulp_regs_t;
  ulp_regs_t s_r;
  ulp_regs_t s_nxt;
  ulp_mem_if mif ();

  ulp_fetch u_fetch
  (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .mif(mif),
    .mem_rd_o(mem_rd_o),
    .mem_addr_o(mem_addr_o),
    .mem_valid_i(mem_valid_i),
    .mem_data_i(mem_data_i)
  );

  always_comb
  begin
    s_nxt = s_r;
    // Software write path; only the base register accepts writes
    if (reg_wr_i && reg_addr_i == ulp_pkg::OFF_COMM_AREA)
      s_nxt.comm_area = reg_wdata_i & ulp_pkg::COMM_AREA_MASK; // [R1] [R3]
    // Walker updates the periodic pointer after each descriptor
    if (periodic_upd_i)
      s_nxt.periodic_cur = periodic_ptr_i & ulp_pkg::PTR_MASK; // [R6] [R7]
    // Initialization fetch of the control list head from the area
    unique case (s_r.st)
      ulp_pkg::ULP_IDLE:
      begin
        if (init_start_i)
          s_nxt.st = ulp_pkg::ULP_FETCH;
      end
      ulp_pkg::ULP_FETCH:
        s_nxt.st = ulp_pkg::ULP_WAIT;
      ulp_pkg::ULP_WAIT:
      begin
        if (mif.done)
        begin
          s_nxt.control_head = mif.data & ulp_pkg::PTR_MASK; // [R10]
          s_nxt.st = ulp_pkg::ULP_IDLE;
        end
      end
    endcase
    // Read path; unmapped offsets read zero
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        ulp_pkg::OFF_COMM_AREA: s_nxt.rdata = s_r.comm_area; // [R1]
        ulp_pkg::OFF_PERIODIC_CUR: s_nxt.rdata = s_r.periodic_cur; // [R8]
        ulp_pkg::OFF_CONTROL_HEAD: s_nxt.rdata = s_r.control_head; // [R9]
        default: s_nxt.rdata = ulp_pkg::RST_VAL;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_r <= '0; // [R11]
    end
    else
      s_r <= s_nxt;
  end

  // Fetch address is inside the shared area
  assign mif.req = (s_r.st == ulp_pkg::ULP_FETCH);
  assign mif.addr = s_r.comm_area + ulp_pkg::OFF_CONTROL_IN_AREA; // [R4] [R10]
  assign init_busy_o = (s_r.st != ulp_pkg::ULP_IDLE);
  assign reg_rdata_o = s_r.rdata;
  assign comm_area_base_o = s_r.comm_area; // [R4]
  assign periodic_current_descriptor_o = s_r.periodic_cur;
  assign control_list_head_o = s_r.control_head; // [R9]

  a_base_low_zero: assert property (@(posedge mclk_i) disable iff (rst_i) // [R1]
    s_r.comm_area[7:0] == 8'h00)
    else $error("base low byte not zero");

  a_base_write: assert property (@(posedge mclk_i) disable iff (rst_i) // [R3]
    reg_wr_i && reg_addr_i == ulp_pkg::OFF_COMM_AREA
    |=> comm_area_base_o == ($past(reg_wdata_i) & ulp_pkg::COMM_AREA_MASK))
    else $error("base write not stored");

  a_periodic_upd: assert property (@(posedge mclk_i) disable iff (rst_i) // [R7]
    periodic_upd_i
    |=> periodic_current_descriptor_o == ($past(periodic_ptr_i) & ulp_pkg::PTR_MASK))
    else $error("periodic pointer not updated");

  a_periodic_ro: assert property (@(posedge mclk_i) disable iff (rst_i) // [R7]
    !periodic_upd_i |=> $stable(periodic_current_descriptor_o))
    else $error("periodic pointer changed without walker");

  a_ptr_low_zero: assert property (@(posedge mclk_i) disable iff (rst_i) // [R6]
    periodic_current_descriptor_o[3:0] == 4'h0 && control_list_head_o[3:0] == 4'h0)
    else $error("pointer low nibble not zero");

  sequence s_init_req;
    init_start_i && !init_busy_o;
  endsequence
  sequence s_fetch_out;
    ##2 mem_rd_o && mem_addr_o == comm_area_base_o + ulp_pkg::OFF_CONTROL_IN_AREA;
  endsequence
  a_init_fetch: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    s_init_req |-> s_fetch_out)
    else $error("init fetch not issued");

  a_head_load: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    mif.done && s_r.st == ulp_pkg::ULP_WAIT
    |=> control_list_head_o == ($past(mif.data) & ulp_pkg::PTR_MASK))
    else $error("control head not loaded");

  a_head_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    !mif.done |=> $stable(control_list_head_o))
    else $error("control head changed outside init");

  a_read_data: assert property (@(posedge mclk_i) disable iff (rst_i) // [R8]
    reg_rd_i && reg_addr_i == ulp_pkg::OFF_PERIODIC_CUR |=> reg_rdata_o == $past(s_r.periodic_cur))
    else $error("periodic read wrong");

  // Register read and write checks
  sequence s_base_rd;
    reg_rd_i && reg_addr_i == ulp_pkg::OFF_COMM_AREA;
  endsequence
  sequence s_head_rd;
    reg_rd_i && reg_addr_i == ulp_pkg::OFF_CONTROL_HEAD;
  endsequence
  sequence s_base_wr;
    reg_wr_i && reg_addr_i == ulp_pkg::OFF_COMM_AREA;
  endsequence

  a_read_base: assert property (@(posedge mclk_i) disable iff (rst_i) // [R1]
    s_base_rd |=> reg_rdata_o == $past(comm_area_base_o)
    && reg_rdata_o[ulp_pkg::COMM_AREA_LSB-1:0] == '0)
    else $error("base read wrong");

  a_read_head: assert property (@(posedge mclk_i) disable iff (rst_i) // [R9]
    s_head_rd |=> reg_rdata_o == $past(control_list_head_o)
    && reg_rdata_o[ulp_pkg::PTR_LSB-1:0] == '0)
    else $error("control head read wrong");

  a_write_read: assert property (@(posedge mclk_i) disable iff (rst_i) // [R3]
    s_base_wr ##1 !reg_wr_i ##1 s_base_rd
    |=> reg_rdata_o == ($past(reg_wdata_i, 3) & ulp_pkg::COMM_AREA_MASK))
    else $error("base write not read back");

  a_read_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // [R8]
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");

  a_base_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // [R3]
    !(reg_wr_i && reg_addr_i == ulp_pkg::OFF_COMM_AREA) |=> $stable(comm_area_base_o))
    else $error("base changed without write");

  // Init fetch checks
  a_busy_start: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    s_init_req |=> init_busy_o)
    else $error("init busy not raised");

  a_busy_end: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    mif.done && s_r.st == ulp_pkg::ULP_WAIT |=> !init_busy_o)
    else $error("init busy not released");

  a_init_wait: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    init_busy_o && !mif.done |=> init_busy_o)
    else $error("init ended without data");

  a_mem_idle: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    !init_busy_o |-> !mem_rd_o)
    else $error("memory read outside init");

  a_fetch_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // [R4]
    mem_rd_o && !mem_valid_i |=> mem_rd_o && $stable(mem_addr_o))
    else $error("fetch request dropped early");

  a_fetch_single: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    mem_rd_o && mem_valid_i |=> !mem_rd_o)
    else $error("fetch request not released");

  // Reset checks
  a_reset_clear: assert property (@(posedge mclk_i) // [R11]
    rst_i |-> comm_area_base_o == ulp_pkg::RST_VAL && control_list_head_o == ulp_pkg::RST_VAL
    && periodic_current_descriptor_o == ulp_pkg::RST_VAL && reg_rdata_o == ulp_pkg::RST_VAL)
    else $error("pointers not cleared by reset");
endmodule

//--- verification/ulp_mem_model.sv
// System memory model: answers each pending read once, after a set delay.
// Assumes the read request stands until the valid pulse has been taken.
`timescale 1ns/100ps
module ulp_mem_model
(
  // Clock
  input wire logic mclk_i,
  // Read port
  input wire logic rd_i,
  input wire logic [3:0] dly_i,
  input wire logic [31:0] word_i,
  output logic valid_o,
  output logic [31:0] data_o
);
  initial
  begin
    valid_o = 1'b0;
    data_o = 32'h5a5a5a5a;
    forever
    begin
      @(negedge mclk_i);
      if (rd_i)
      begin
        repeat (dly_i) @(negedge mclk_i);
        valid_o = 1'b1;
        data_o = word_i;
        @(negedge mclk_i);
        valid_o = 1'b0;
        data_o = ~word_i;
      end
    end
  end
endmodule

//--- verification/tb.sv
// Self-checking bench for the list pointer register bank.
// Assumes inputs driven at the falling edge and a memory model on the read port.
`timescale 1ns/100ps
module tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} ulp_row_t;
  logic mclk_i = 1'b1;
  logic rst_i = 1'b0;
  logic wr = 1'b0, rd = 1'b0, ist = 1'b0, upd = 1'b0, mrd, mval, busy;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = '0, pp = '0, rdat, base, per, head, madr, mdat, word = '0;
  logic [3:0] dly = 4'h0;
  int mismatches = 0, checked = 0;
  ulp_row_t rows [5] = '{'{8'h18, 32'hffffffff, 32'hffffff00}, '{8'h1c, 32'hfffffff0, 32'h0},
    '{8'h20, 32'hfffffff0, 32'h0}, '{8'h24, 32'hffffffff, 32'h0},
    '{8'h18, 32'h12345600, 32'h12345600}};
  always #2 mclk_i = ~mclk_i;
  ulp_regs dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(adr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .init_start_i(ist),
    .init_busy_o(busy), .periodic_upd_i(upd), .periodic_ptr_i(pp),
    .comm_area_base_o(base), .periodic_current_descriptor_o(per),
    .control_list_head_o(head), .mem_rd_o(mrd), .mem_addr_o(madr),
    .mem_valid_i(mval), .mem_data_i(mdat));
  ulp_mem_model mem_u (.mclk_i(mclk_i), .rd_i(mrd), .dly_i(dly), .word_i(word),
    .valid_o(mval), .data_o(mdat));
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk_i) {wr, adr, wd} = {1'b1, a, d};
    @(negedge mclk_i) wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(negedge mclk_i) {rd, adr} = {1'b1, a};
    @(negedge mclk_i) rd = 1'b0;
    @(negedge mclk_i) check("rdata", rdat, e);
  endtask
  task automatic init_run(input logic [3:0] d, input logic [31:0] w);
    {dly, word} = {d, w};
    @(negedge mclk_i) ist = 1'b1;
    @(negedge mclk_i) check("busy", busy, 32'h1);
    @(negedge mclk_i) ist = 1'b0;
    for (int i = 0; i < 20 && mrd !== 1'b1; i++) @(negedge mclk_i);
    check("mem_rd", mrd, 32'h1);
    check("mem_addr", madr, 32'h12345604);
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge mclk_i);
    check("busy", busy, 32'h0);
    check("head", head, w & 32'hfffffff0);
    rreg(8'h20, w & 32'hfffffff0);
  endtask
  task automatic reset_check;
    check("base", base, 32'h0);
    check("per", per, 32'h0);
    check("head", head, 32'h0);
    check("rdata", rdat, 32'h0);
    check("busy", busy, 32'h0);
    check("mem_rd", mrd, 32'h0);
    rreg(8'h18, 32'h0);
  endtask
  task print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    mismatches++;
    print_verdict();
  end
  initial
  begin
    @(negedge mclk_i) rst_i = 1'b1;
    repeat (12) @(negedge mclk_i);
    rst_i = 1'b0;
    reset_check();
    foreach (rows[i])
    begin
      wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, rows[i].e);
    end
    check("base_o", base, 32'h12345600);
    @(negedge mclk_i) {upd, pp} = {1'b1, 32'habcdef5f};
    @(negedge mclk_i) pp = 32'h1234567c;
    check("per", per, 32'habcdef50);
    @(negedge mclk_i) upd = 1'b0;
    check("per", per, 32'h12345670);
    rreg(8'h1c, 32'h12345670);
    init_run(4'h0, 32'hfeedbeef);
    init_run(4'h5, 32'h0badf00d);
    @(negedge mclk_i) rst_i = 1'b1;
    @(negedge mclk_i) rst_i = 1'b0;
    reset_check();
    print_verdict();
  end
endmodule
